// ---- core/asi_cfg_pkg.sv ----
// constants, register map and types for the serial slot and master configuration block
package asi_cfg_pkg;
  localparam int          REG_ADDR_W          = 8;
  localparam int          REG_DATA_W          = 8;
  localparam int          SLOT_CODE_W         = 6;
  localparam int          HALF_SLOT_W         = 5;
  localparam int          REFCLK_CODE_W       = 3;
  localparam int          RATIO_CODE_W        = 3;

  localparam logic [7:0]  OFS_CHAN3_SLOT_CODE        = 8'h0D;
  localparam logic [7:0]  OFS_CHAN4_SLOT_CODE        = 8'h0E;
  localparam logic [7:0]  OFS_MASTER_CFG0     = 8'h13;

  localparam logic [7:0]  RST_CHAN3_SLOT_CODE        = 8'h02;
  localparam logic [7:0]  RST_CHAN4_SLOT_CODE        = 8'h03;
  localparam logic [7:0]  RST_MASTER_CFG0     = 8'h02;

  localparam logic [7:0]  SLOT_FIELD_MASK     = 8'h3F;
  localparam int          BIT_ROLE            = 7;
  localparam int          BIT_AUTO_CLK_OFF    = 6;
  localparam int          BIT_AUTO_PLL_OFF    = 5;
  localparam int          BIT_CLOCKS_GATE     = 4;
  localparam int          BIT_RATE_FAMILY     = 3;
  localparam int          REFCLK_MSB          = 2;
  localparam int          SLOT_RIGHT_BIT      = 5;

  localparam logic [7:0]  DATA_ZERO           = 8'h00;

  typedef enum logic [1:0] {
    FMT_TDM,
    FMT_I2S,
    FMT_LJ
  } frame_format_t;

  // reference clock rate in kHz for each code 0..7
  function automatic logic [15:0] refclk_khz(input logic [2:0] code);
    logic [15:0] r;
    r = 16'h0000;
    unique case (code)
      3'h0: r = 16'h2EE0;
      3'h1: r = 16'h3000;
      3'h2: r = 16'h32C8;
      3'h3: r = 16'h3E80;
      3'h4: r = 16'h4B00;
      3'h5: r = 16'h4CE0;
      3'h6: r = 16'h5DC0;
      3'h7: r = 16'h6000;
    endcase
    return r;
  endfunction
endpackage

// ---- core/asi_slot_and_master_cfg.sv ----
// register file and frame-aligned configuration outputs for the serial port
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - channel 3 slot code, reset two
// - channel 4 slot code, reset three
// - codes 0-31: tdm slot or left half
// - codes 32-63: tdm slot or right half
// - role bit set drives clocks, else inputs
// - auto clock bit clear derives dividers itself
// - auto mode runs pll unless bit5 set
// - master gate bit stops outgoing clocks
// - master rate family 48k or 44.1k
// - 3-bit reference clock code, reset 010b
// - refclk code used only master, mode zero
// - mode one: refclk is frame-sync ratio multiple
module asi_slot_and_master_cfg
  import asi_cfg_pkg::*;
(
  input  wire logic                     i_clk,
  input  wire logic                     i_srst,
  input  wire logic                     i_reg_wr,
  input  wire logic                     i_reg_rd,
  input  wire logic [REG_ADDR_W-1:0]    i_reg_addr,
  input  wire logic [REG_DATA_W-1:0]    i_reg_wdata,
  input  wire logic                     i_refclk_spec_mode,
  input  wire logic [RATIO_CODE_W-1:0]  i_refclk_ratio_code,
  input  wire logic                     i_frame_start,
  output logic      [REG_DATA_W-1:0]    o_reg_rdata,
  output logic                          o_reg_hit,
  output logic      [SLOT_CODE_W-1:0]   o_ch3_tdm_slot,
  output logic                          o_ch3_right_half,
  output logic      [HALF_SLOT_W-1:0]   o_ch3_half_slot,
  output logic      [SLOT_CODE_W-1:0]   o_ch4_tdm_slot,
  output logic                          o_ch4_right_half,
  output logic      [HALF_SLOT_W-1:0]   o_ch4_half_slot,
  output logic                          o_serial_clocks_drive,
  output logic                          o_serial_clocks_run,
  output logic                          o_auto_clock_derive,
  output logic                          o_pll_enable,
  output logic                          o_rate_family_441,
  output logic                          o_refclk_code_valid,
  output logic      [REFCLK_CODE_W-1:0] o_refclk_freq_code,
  output logic      [15:0]              o_refclk_khz,
  output logic                          o_refclk_by_ratio,
  output logic      [RATIO_CODE_W-1:0]  o_refclk_ratio_code
);
  // software-visible registers
  logic [SLOT_CODE_W-1:0] chan3_slot_code;
  logic [SLOT_CODE_W-1:0] chan4_slot_code;
  logic [REG_DATA_W-1:0]  serial_master_cfg0;

  // copies in force for the current frame
  logic [SLOT_CODE_W-1:0] live_ch3;
  logic [SLOT_CODE_W-1:0] live_ch4;
  logic [REG_DATA_W-1:0]  live_cfg;
  logic                   live_spec_mode;
  logic [RATIO_CODE_W-1:0] live_ratio;

  wire hit_ch3 = (i_reg_addr == OFS_CHAN3_SLOT_CODE);
  wire hit_ch4 = (i_reg_addr == OFS_CHAN4_SLOT_CODE);
  wire hit_cfg = (i_reg_addr == OFS_MASTER_CFG0);
  wire hit_any = hit_ch3 | hit_ch4 | hit_cfg;

  // bits 7-6 of the slot registers are not stored, so they always read zero
  wire [REG_DATA_W-1:0] wdata_slot = i_reg_wdata & SLOT_FIELD_MASK;

  wire [REG_DATA_W-1:0] read_mux =
    hit_ch3 ? {2'b00, chan3_slot_code} :
    hit_ch4 ? {2'b00, chan4_slot_code} :
    hit_cfg ? serial_master_cfg0 : DATA_ZERO;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      chan3_slot_code    <= RST_CHAN3_SLOT_CODE[SLOT_CODE_W-1:0];
      chan4_slot_code    <= RST_CHAN4_SLOT_CODE[SLOT_CODE_W-1:0];
      serial_master_cfg0 <= RST_MASTER_CFG0;
    end else if (i_reg_wr) begin
      if (hit_ch3) chan3_slot_code <= wdata_slot[SLOT_CODE_W-1:0];
      if (hit_ch4) chan4_slot_code <= wdata_slot[SLOT_CODE_W-1:0];
      if (hit_cfg) serial_master_cfg0 <= i_reg_wdata;
    end
  end

  // read data is registered; unmapped offsets answer zero
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_reg_rdata <= DATA_ZERO;
      o_reg_hit   <= 1'b0;
    end else begin
      o_reg_rdata <= i_reg_rd ? read_mux : DATA_ZERO;
      o_reg_hit   <= i_reg_rd & hit_any;
    end
  end

  // settings move to the live copies only at frame start; a write in the same
  // cycle is picked up at the next frame, never half-applied
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      live_ch3       <= RST_CHAN3_SLOT_CODE[SLOT_CODE_W-1:0];
      live_ch4       <= RST_CHAN4_SLOT_CODE[SLOT_CODE_W-1:0];
      live_cfg       <= RST_MASTER_CFG0;
      live_spec_mode <= 1'b0;
      live_ratio     <= '0;
    end else if (i_frame_start) begin
      live_ch3       <= chan3_slot_code;
      live_ch4       <= chan4_slot_code;
      live_cfg       <= serial_master_cfg0;
      live_spec_mode <= i_refclk_spec_mode;
      live_ratio     <= i_refclk_ratio_code;
    end
  end

  slot_map_if ch3_map ();
  slot_map_if ch4_map ();

  slot_decode u_ch3 (
    .i_code (live_ch3),
    .map    (ch3_map)
  );
  slot_decode u_ch4 (
    .i_code (live_ch4),
    .map    (ch4_map)
  );

  wire is_master   = live_cfg[BIT_ROLE];
  wire auto_clk    = ~live_cfg[BIT_AUTO_CLK_OFF];
  wire [REFCLK_CODE_W-1:0] rc_code = live_cfg[REFCLK_MSB:0];
  wire [15:0] rc_khz = refclk_khz(rc_code);

  // data outputs from flip-flops
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_ch3_tdm_slot        <= RST_CHAN3_SLOT_CODE[SLOT_CODE_W-1:0];
      o_ch3_right_half      <= 1'b0;
      o_ch3_half_slot       <= RST_CHAN3_SLOT_CODE[HALF_SLOT_W-1:0];
      o_ch4_tdm_slot        <= RST_CHAN4_SLOT_CODE[SLOT_CODE_W-1:0];
      o_ch4_right_half      <= 1'b0;
      o_ch4_half_slot       <= RST_CHAN4_SLOT_CODE[HALF_SLOT_W-1:0];
      o_serial_clocks_drive <= 1'b0;
      o_serial_clocks_run   <= 1'b0;
      o_auto_clock_derive   <= 1'b1;
      o_pll_enable          <= 1'b1;
      o_rate_family_441     <= 1'b0;
      o_refclk_code_valid   <= 1'b0;
      o_refclk_freq_code    <= RST_MASTER_CFG0[REFCLK_CODE_W-1:0];
      o_refclk_khz          <= 16'h0000;
      o_refclk_by_ratio     <= 1'b0;
      o_refclk_ratio_code   <= '0;
    end else begin
      o_ch3_tdm_slot        <= ch3_map.tdm_slot;
      o_ch3_right_half      <= ch3_map.right_half;
      o_ch3_half_slot       <= ch3_map.half_slot;
      o_ch4_tdm_slot        <= ch4_map.tdm_slot;
      o_ch4_right_half      <= ch4_map.right_half;
      o_ch4_half_slot       <= ch4_map.half_slot;
      o_serial_clocks_drive <= is_master;
      // gate bit only counts in master mode; slave clocks come from outside
      o_serial_clocks_run   <= is_master & ~live_cfg[BIT_CLOCKS_GATE];
      o_auto_clock_derive   <= auto_clk;
      o_pll_enable          <= auto_clk & ~live_cfg[BIT_AUTO_PLL_OFF];
      o_rate_family_441     <= is_master & live_cfg[BIT_RATE_FAMILY];
      o_refclk_code_valid   <= is_master & ~live_spec_mode;
      o_refclk_freq_code    <= rc_code;
      o_refclk_khz          <= (is_master & ~live_spec_mode) ? rc_khz : 16'h0000;
      o_refclk_by_ratio     <= is_master & live_spec_mode;
      o_refclk_ratio_code   <= live_ratio;
    end
  end
endmodule
`default_nettype wire

// ---- core/slot_decode.sv ----
// decodes a 6-bit slot code into tdm slot or half-frame slot placement
`timescale 1ns/10ps
`default_nettype none
module slot_decode
  import asi_cfg_pkg::*;
(
  input  wire logic [SLOT_CODE_W-1:0] i_code,
  slot_map_if.producer                 map
);
  assign map.tdm_slot   = i_code;
  assign map.right_half = i_code[SLOT_RIGHT_BIT];
  assign map.half_slot  = i_code[HALF_SLOT_W-1:0];
endmodule
`default_nettype wire

// ---- core/slot_map_if.sv ----
// interface carrying one channel's decoded slot placement
`timescale 1ns/10ps
`default_nettype none
interface slot_map_if;
  logic [5:0] tdm_slot;
  logic       right_half;
  logic [4:0] half_slot;
  modport producer (output tdm_slot, output right_half, output half_slot);
  modport consumer (input tdm_slot, input right_half, input half_slot);
endinterface
`default_nettype wire

// ---- verification/asi_cfg_asserts.sv ----
// port checks for the slot and master configuration block
`timescale 1ns/10ps
`default_nettype none
module asi_cfg_asserts
  import asi_cfg_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_reg_rd,
  input wire logic        i_frame_start,
  input wire logic        o_reg_hit,
  input wire logic        o_ch3_right_half,
  input wire logic        o_serial_clocks_drive,
  input wire logic        o_serial_clocks_run,
  input wire logic        o_auto_clock_derive,
  input wire logic        o_pll_enable,
  input wire logic        o_rate_family_441,
  input wire logic        o_refclk_code_valid,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic [5:0]  o_ch3_tdm_slot,
  input wire logic [5:0]  o_ch4_tdm_slot,
  input wire logic [4:0]  o_ch3_half_slot,
  input wire logic [15:0] o_refclk_khz
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_slot_split: assert property (
    o_ch3_half_slot == o_ch3_tdm_slot[4:0] && o_ch3_right_half == o_ch3_tdm_slot[5])
    else $error("ch3 half slot wrong");
  a_run_gated: assert property (o_serial_clocks_run |-> o_serial_clocks_drive)
    else $error("clocks run in slave");
  a_family_master: assert property (o_rate_family_441 |-> o_serial_clocks_drive)
    else $error("rate family in slave");
  a_pll_auto: assert property (o_pll_enable |-> o_auto_clock_derive)
    else $error("pll on outside auto");
  a_khz_idle: assert property (!o_refclk_code_valid |-> o_refclk_khz == 16'h0000)
    else $error("refclk rate shown unused");
  a_code_master: assert property (o_refclk_code_valid |-> o_serial_clocks_drive)
    else $error("refclk code in slave");
  a_frame_hold: assert property (
    $changed(o_ch4_tdm_slot) || $changed(o_serial_clocks_drive)
    |-> $past(i_frame_start) || $past(i_frame_start, 2)) else $error("change off frame");
  a_read_slot: assert property (
    $past(i_reg_rd) && $past(i_reg_addr) == OFS_CHAN3_SLOT_CODE |-> o_reg_hit && o_reg_rdata[7:6] == 2'h0)
    else $error("slot read bad");
  c_run: cover property ($rose(o_serial_clocks_run));
  c_family: cover property (o_rate_family_441);
  c_right: cover property (o_ch3_right_half);
endmodule
bind asi_slot_and_master_cfg asi_cfg_asserts chk (.i_clk(i_clk), .i_srst(i_srst),
  .i_reg_rd(i_reg_rd), .i_frame_start(i_frame_start), .o_reg_hit(o_reg_hit),
  .o_ch3_right_half(o_ch3_right_half), .o_serial_clocks_drive(o_serial_clocks_drive),
  .o_serial_clocks_run(o_serial_clocks_run), .o_auto_clock_derive(o_auto_clock_derive),
  .o_pll_enable(o_pll_enable), .o_rate_family_441(o_rate_family_441),
  .o_refclk_code_valid(o_refclk_code_valid), .i_reg_addr(i_reg_addr),
  .o_reg_rdata(o_reg_rdata), .o_ch3_tdm_slot(o_ch3_tdm_slot),
  .o_ch4_tdm_slot(o_ch4_tdm_slot), .o_ch3_half_slot(o_ch3_half_slot),
  .o_refclk_khz(o_refclk_khz));
`default_nettype wire

// ---- verification/frame_host.sv ----
// far-side model: one frame-start pulse a chosen delay after each request
`timescale 1ns/10ps
`default_nettype none
module frame_host (
  input  wire logic       i_clk,
  input  wire logic       i_req,
  input  wire logic [2:0] i_wait,
  output logic            o_frame_start
);
  logic [2:0] cnt = 3'h0;
  logic       busy = 1'b0;
  initial o_frame_start = 1'b0;
  // delay 0 answers promptly, up to 7 stalls the frame
  always @(posedge i_clk) begin
    o_frame_start <= busy && cnt == 3'h0;
    busy <= i_req || (busy && cnt != 3'h0);
    cnt <= i_req ? i_wait : cnt - 3'h1;
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the slot and master configuration block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import asi_cfg_pkg::*;
  localparam logic [15:0] KHZ [8] = '{16'h2EE0, 16'h3000, 16'h32C8, 16'h3E80,
                                      16'h4B00, 16'h4CE0, 16'h5DC0, 16'h6000};
  localparam logic [5:0]  EDGES [4] = '{6'h00, 6'h1F, 6'h20, 6'h3F};
  logic clk = 0, srst = 1, wr = 0, rd = 0, sm = 0, req = 0, rd_prev = 0;
  logic [7:0] addr = 0, wd = 0, rdata, v, pv;
  logic [2:0] rc = 0, dly = 0, code, rco;
  logic [5:0] c, pc, t3, t4;
  logic [4:0] h3, h4;
  logic [15:0] khz;
  logic [8:0] q [$];
  logic hit, r3, r4, drv, run, aut, pll, f441, cv, byr, fs;
  int compares = 0, miscompares = 0;
  always #10 clk = ~clk;
  frame_host host (.i_clk(clk), .i_req(req), .i_wait(dly), .o_frame_start(fs));
  asi_slot_and_master_cfg uut (.i_clk(clk), .i_srst(srst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wd), .i_refclk_spec_mode(sm), .i_refclk_ratio_code(rc),
    .i_frame_start(fs), .o_reg_rdata(rdata), .o_reg_hit(hit), .o_ch3_tdm_slot(t3),
    .o_ch3_right_half(r3), .o_ch3_half_slot(h3), .o_ch4_tdm_slot(t4), .o_ch4_right_half(r4),
    .o_ch4_half_slot(h4), .o_serial_clocks_drive(drv), .o_serial_clocks_run(run),
    .o_auto_clock_derive(aut), .o_pll_enable(pll), .o_rate_family_441(f441),
    .o_refclk_code_valid(cv), .o_refclk_freq_code(code), .o_refclk_khz(khz),
    .o_refclk_by_ratio(byr), .o_refclk_ratio_code(rco));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic stop_test;
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // read data lands one cycle after the read edge
  always @(posedge clk) begin
    #2;
    if (rd_prev) chk("read", {23'h0, q.pop_front()}, {23'h0, hit, rdata});
    rd_prev = rd;
  end
  task automatic bus(input logic w, input logic [7:0] a, d, input logic [8:0] e);
    wr = w; rd = !w; addr = a; wd = d;
    if (!w) q.push_back(e);
    @(posedge clk) #1;
    wr = 0; rd = 0;
    @(posedge clk) #1;
  endtask
  task automatic frame;
    int n;
    n = 0;
    req = 1; dly = 3'($urandom % 8);
    @(posedge clk) #1 req = 0;
    while (fs !== 1'b1 && n < 20) begin
      @(posedge clk) #1 n++;
    end
    if (n == 20) begin
      miscompares++;
      $display("BAD frame_start exp 1 got %b", fs);
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic chk_slot(input logic [5:0] a, b);
    chk("ch3", {a, a[5], a[4:0]}, {t3, r3, h3});
    chk("ch4", {b, b[5], b[4:0]}, {t4, r4, h4});
  endtask
  task automatic chk_cfg(input logic [7:0] x);
    logic ok;
    ok = x[7] & !sm;
    chk("drive", x[7], drv);
    chk("run", x[7] & !x[4], run);
    chk("auto", {!x[6], !x[6] & !x[5]}, {aut, pll});
    chk("f441", x[7] & x[3], f441);
    chk("refclk", {ok, x[2:0], ok ? KHZ[x[2:0]] : 16'h0000}, {cv, code, khz});
    chk("ratio", {x[7] & sm, rc}, {byr, rco});
  endtask
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
  initial begin
    void'($urandom(92));
    repeat (2) @(posedge clk);
    #1 srst = 0;
    chk_slot(6'h02, 6'h03);
    chk_cfg(RST_MASTER_CFG0);
    bus(0, OFS_CHAN3_SLOT_CODE, 0, 9'h102);
    bus(0, OFS_CHAN4_SLOT_CODE, 0, 9'h103);
    bus(0, OFS_MASTER_CFG0, 0, 9'h102);
    bus(0, 8'h00, 0, 9'h000);
    pc = 6'h02; pv = RST_MASTER_CFG0;
    for (int i = 0; i < 16; i++) begin
      c = (i < 4) ? EDGES[i] : 6'($urandom);
      v = {5'($urandom), 3'(i)};
      bus(1, OFS_CHAN3_SLOT_CODE, {2'b11, c}, 0);
      bus(1, OFS_CHAN4_SLOT_CODE, {2'b00, ~c}, 0);
      bus(1, OFS_MASTER_CFG0, v, 0);
      bus(0, OFS_CHAN3_SLOT_CODE, 0, {3'b100, c});
      bus(0, OFS_MASTER_CFG0, 0, {1'b1, v});
      // first pass still shows reset placement; the edge code 00 written there must not look like it
      if (i == 0) chk_slot(6'h02, 6'h03);
      else chk_slot(pc, ~pc);
      chk_cfg(pv);
      sm = 1'($urandom); rc = 3'($urandom);
      frame();
      chk_slot(c, ~c);
      chk_cfg(v);
      pc = c; pv = v;
    end
    stop_test();
  end
endmodule
`default_nettype wire
